// [hdl/wdt_pkg.sv]
/*
  Shared constants for the watchdog block: register indices and byte
  addresses, field positions, reset value, key codes, divider widths,
  reset-hold timing and the control state encoding.
  Assumes a 100 MHz pclk that also serves as the high-frequency clock.
*/
package wdt_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0]  WDT_SETUP_IDX   = 8'h34;
  localparam logic [7:0]  WDT_KEY_IDX     = 8'h35;
  localparam logic [7:0]  WDT_STATUS_IDX  = 8'h36;
  localparam logic [11:0] WDT_SETUP_ADDR  = {2'h0, WDT_SETUP_IDX, 2'h0};
  localparam logic [11:0] WDT_KEY_ADDR    = {2'h0, WDT_KEY_IDX, 2'h0};
  localparam logic [11:0] WDT_STATUS_ADDR = {2'h0, WDT_STATUS_IDX, 2'h0};

  // Field positions of wdt_control_one
  localparam int unsigned WDT_BIT_ACTION   = 0;
  localparam int unsigned WDT_BIT_TIME_LO  = 1;
  localparam int unsigned WDT_BIT_TIME_HI  = 2;
  localparam int unsigned WDT_BIT_ENABLE   = 3;
  localparam int unsigned WDT_BIT_TRAP_ACT = 4;
  localparam int unsigned WDT_BIT_RAM_TRAP = 5;
  localparam logic [7:0]  WDT_SETUP_RESET  = 8'h39;

  // Field positions of the status word
  localparam int unsigned WDT_ST_RUNNING  = 0;
  localparam int unsigned WDT_ST_ACTION   = 1;
  localparam int unsigned WDT_ST_CNT_LO   = 2;
  localparam int unsigned WDT_ST_CNT_HI   = 3;
  localparam int unsigned WDT_ST_TRAP     = 4;
  localparam int unsigned WDT_ST_RSTHOLD  = 5;
  localparam int unsigned WDT_ST_TIME_LO  = 6;
  localparam int unsigned WDT_ST_TIME_HI  = 7;

  // Key codes for wdt_code_register
  localparam logic [7:0] WDT_CODE_CLEAR   = 8'h4E;
  localparam logic [7:0] WDT_CODE_DISABLE = 8'hB1;
  localparam logic [7:0] WDT_CODE_TRAP    = 8'hD2;

  // Divider widths give taps 2^(W-2k); the 2-bit counter adds 2^2
  localparam int unsigned WDT_HF_DIV_W = 23;
  localparam int unsigned WDT_LF_DIV_W = 15;
  localparam int unsigned WDT_CNT_W    = 2;
  localparam logic [1:0]  WDT_CNT_LAST = 2'h3;

  // Reset request hold: 24 high-frequency periods at most
  localparam int unsigned WDT_CLK_PERIOD_NS    = 10;
  localparam int unsigned WDT_RST_HOLD_PERIODS = 24;
  localparam int unsigned WDT_RST_HOLD_NS      =
    WDT_RST_HOLD_PERIODS * WDT_CLK_PERIOD_NS;
  localparam int unsigned WDT_RST_HOLD_CYC     =
    WDT_RST_HOLD_NS / WDT_CLK_PERIOD_NS;
  localparam logic [4:0]  WDT_RST_HOLD_LAST    =
    5'(WDT_RST_HOLD_CYC - 1);

  typedef enum logic [2:0] {
    WDT_S_OFF     = 3'h1,
    WDT_S_RUN     = 3'h2,
    WDT_S_RSTHOLD = 3'h4
  } wdt_state_e;

endpackage

// [hdl/wdt_tick_if.sv]
/*
  Carrier between the watchdog control logic and its prescaler:
  hold, low-frequency tick, tap selection and the resulting tap pulse.
  Assumes both ends run on pclk.
*/
`timescale 1ns/1ps
interface wdt_tick_if;
  logic       hold;
  logic       lf_tick;
  logic       use_low;
  logic [1:0] tap_sel;
  logic       tick;

  modport divider (input hold, input lf_tick, input use_low,
                   input tap_sel, output tick);
  modport ctrl    (output hold, output lf_tick, output use_low,
                   output tap_sel, input tick);
endinterface

// [hdl/wdt_divider.sv]
/*
  Free-running prescaler of the watchdog: one chain on pclk and one on
  the low-frequency tick, each with four taps two bits apart.
  Assumes lf_tick is a one-cycle pulse synchronous to pclk.
*/
`timescale 1ns/1ps
module wdt_divider #(
  parameter int unsigned HF_W = wdt_pkg::WDT_HF_DIV_W,
  parameter int unsigned LF_W = wdt_pkg::WDT_LF_DIV_W
) (
  input  wire logic   pclk,
  input  wire logic   presetn,
  wdt_tick_if.divider tb
);

  logic [HF_W-1:0] hf_q;
  logic [LF_W-1:0] lf_q;
  logic [3:0]      hf_wrap;
  logic [3:0]      lf_wrap;
  logic            hf_sel;
  logic            lf_sel;

  // Tap k wraps every 2^(W-2k) steps of its chain
  for (genvar k = 0; k < 4; k++) begin : g_tap
    assign hf_wrap[k] = &hf_q[HF_W-1-2*k:0];
    assign lf_wrap[k] = tb.lf_tick & (&lf_q[LF_W-1-2*k:0]);
  end

  assign hf_sel  = hf_wrap[tb.tap_sel];
  assign lf_sel  = lf_wrap[tb.tap_sel];
  assign tb.tick = ~tb.hold & (tb.use_low ? lf_sel : hf_sel);

  // Never cleared by the clear code, only by reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hf_q <= '0;
      lf_q <= '0;
    end else begin
      if (!tb.hold) begin
        hf_q <= hf_q + 1'b1;
      end
      if (!tb.hold && tb.lf_tick) begin
        lf_q <= lf_q + 1'b1;
      end
    end
  end

endmodule // wdt_divider

// [hdl/wdt_core.sv]
/*
  Watchdog timer with key codes and address-trap area commit, reached
  over APB. Prescaler in wdt_divider, two-stage binary counter here.
  Assumes pclk is the high-frequency clock, low_freq_tick a one-cycle
  pulse per low-frequency period, and mode inputs synchronous to pclk.
*/
//
// Functional notes
// - Reset selects reset request; change once only
// - Action bit cannot return to one
// - Setup resets enabled, time 00, reset action
// - Overflow gives reset or interrupt per action
// - Counter holds in stop, idle, sleep
// - Clear code zeroes counter, not divider
// - Time code selects one of four taps
// - Setup register write-only, reads undefined
// - Decode clear, disable, trap codes; others ignored
// - Disable code acts only with enable bit low
// - Disabled watchdog holds counter at zero
// - Overflow interrupt ignores master interrupt flag
// - New overflow interrupt nests over running one
// - Interrupt action repeats on every overflow
// - Reset request lasts at most 24 periods
`timescale 1ns/1ps
module wdt_core #(
  parameter int unsigned HF_DIV_W = wdt_pkg::WDT_HF_DIV_W,
  parameter int unsigned LF_DIV_W = wdt_pkg::WDT_LF_DIV_W
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        low_freq_tick,
  input  wire logic        slow_mode,
  input  wire logic        low_power_hold,
  input  wire logic        divider_tap_select,
  output logic             watchdog_overflow_irq,
  output logic             wdt_reset_req,
  output logic             trap_ram_enable,
  output logic             trap_action_reset,
  output logic             wdt_running
);

  logic [7:0]                   setup_q;
  logic [7:0]                   setup_d;
  logic [wdt_pkg::WDT_CNT_W-1:0] cnt_q;
  logic [wdt_pkg::WDT_CNT_W-1:0] cnt_d;
  wdt_pkg::wdt_state_e          state_q;
  wdt_pkg::wdt_state_e          state_d;
  logic [4:0]                   hold_cnt_q;
  logic [4:0]                   hold_cnt_d;
  logic                         trap_armed_q;
  logic                         trap_armed_d;
  logic                         irq_q;
  logic                         rst_req_q;
  logic                         trap_act_q;
  logic                         running_q;
  logic [31:0]                  prdata_q;
  logic [31:0]                  prdata_d;
  logic                         pready_q;
  logic                         pslverr_q;

  wdt_tick_if tick_bus ();

  wdt_divider #(
    .HF_W (HF_DIV_W),
    .LF_W (LF_DIV_W)
  ) u_divider (
    .pclk    (pclk),
    .presetn (presetn),
    .tb      (tick_bus.divider)
  );

  // APB decode: one wait state, data and error land with pready
  wire access_phase = psel & penable & ~pready_q;
  wire commit       = psel & penable & pready_q;
  wire hit_setup    = (paddr == wdt_pkg::WDT_SETUP_ADDR);
  wire hit_key      = (paddr == wdt_pkg::WDT_KEY_ADDR);
  wire hit_status   = (paddr == wdt_pkg::WDT_STATUS_ADDR);
  wire addr_hit     = hit_setup | hit_key | hit_status;
  wire in_rsthold   = (state_q == wdt_pkg::WDT_S_RSTHOLD);
  wire is_running   = (state_q == wdt_pkg::WDT_S_RUN);

  // Writes are refused while the internal reset is being held
  wire wr_ok        = commit & pwrite & pstrb[0] & ~in_rsthold;
  wire wr_setup     = wr_ok & hit_setup;
  wire wr_key       = wr_ok & hit_key;
  wire [7:0] wbyte  = pwdata[7:0];

  wire code_clear   = wr_key & (wbyte == wdt_pkg::WDT_CODE_CLEAR);
  wire code_trap    = wr_key & (wbyte == wdt_pkg::WDT_CODE_TRAP);
  wire code_disable = wr_key & (wbyte == wdt_pkg::WDT_CODE_DISABLE)
                      & ~setup_q[wdt_pkg::WDT_BIT_ENABLE];

  // A one in the enable bit restarts a stopped watchdog
  wire enable_write = wr_setup & wbyte[wdt_pkg::WDT_BIT_ENABLE];

  wire action_reset = setup_q[wdt_pkg::WDT_BIT_ACTION];
  wire [1:0] time_sel =
    setup_q[wdt_pkg::WDT_BIT_TIME_HI:wdt_pkg::WDT_BIT_TIME_LO];

  // Prescaler hookup
  assign tick_bus.hold    = low_power_hold;
  assign tick_bus.lf_tick = low_freq_tick;
  assign tick_bus.use_low = divider_tap_select | slow_mode;
  assign tick_bus.tap_sel = time_sel;

  // Step only while running; a clear in the same cycle wins
  wire step      = is_running & tick_bus.tick & ~code_clear;
  wire overflow  = step & (cnt_q == wdt_pkg::WDT_CNT_LAST);
  wire hold_done = in_rsthold & (hold_cnt_q == wdt_pkg::WDT_RST_HOLD_LAST);

  // Setup register: action bit may only fall until the next reset
  always_comb begin
    setup_d = setup_q;
    if (hold_done) begin
      setup_d = wdt_pkg::WDT_SETUP_RESET;
    end else if (wr_setup) begin
      setup_d = wbyte;
      setup_d[wdt_pkg::WDT_BIT_ACTION] =
        setup_q[wdt_pkg::WDT_BIT_ACTION]
        & wbyte[wdt_pkg::WDT_BIT_ACTION];
    end
  end

  // Trap area is armed only by the trap code, from the setup bit
  always_comb begin
    trap_armed_d = trap_armed_q;
    if (hold_done) begin
      trap_armed_d = 1'b0;
    end else if (code_trap) begin
      trap_armed_d = setup_q[wdt_pkg::WDT_BIT_RAM_TRAP];
    end
  end

  // Control state
  always_comb begin
    state_d = state_q;
    case (state_q)
      wdt_pkg::WDT_S_RUN: begin
        if (overflow && action_reset) begin
          state_d = wdt_pkg::WDT_S_RSTHOLD;
        end else if (code_disable) begin
          state_d = wdt_pkg::WDT_S_OFF;
        end
      end
      wdt_pkg::WDT_S_OFF: begin
        if (enable_write) begin
          state_d = wdt_pkg::WDT_S_RUN;
        end
      end
      wdt_pkg::WDT_S_RSTHOLD: begin
        if (hold_done) begin
          state_d = wdt_pkg::WDT_S_RUN;
        end
      end
      default: begin
        state_d = wdt_pkg::WDT_S_RUN;
      end
    endcase
  end

  // Binary counter: zero when stopped, cleared, or after overflow
  always_comb begin
    cnt_d = cnt_q;
    if (!is_running || code_clear) begin
      cnt_d = '0;
    end else if (code_disable) begin
      cnt_d = '0;
    end else if (step) begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_comb begin
    hold_cnt_d = '0;
    if (in_rsthold && !hold_done) begin
      hold_cnt_d = hold_cnt_q + 1'b1;
    end
  end

  // Read data: both control registers read as zero
  always_comb begin
    prdata_d = '0;
    if (hit_status && !pwrite) begin
      prdata_d[wdt_pkg::WDT_ST_RUNNING] = is_running;
      prdata_d[wdt_pkg::WDT_ST_ACTION]  = action_reset;
      prdata_d[wdt_pkg::WDT_ST_CNT_HI:wdt_pkg::WDT_ST_CNT_LO] = cnt_q;
      prdata_d[wdt_pkg::WDT_ST_TRAP]    = trap_armed_q;
      prdata_d[wdt_pkg::WDT_ST_RSTHOLD] = in_rsthold;
      prdata_d[wdt_pkg::WDT_ST_TIME_HI:wdt_pkg::WDT_ST_TIME_LO] = time_sel;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setup_q <= wdt_pkg::WDT_SETUP_RESET;
      state_q <= wdt_pkg::WDT_S_RUN;
    end else begin
      setup_q <= setup_d;
      state_q <= state_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q        <= '0;
      hold_cnt_q   <= '0;
      trap_armed_q <= 1'b0;
    end else begin
      cnt_q        <= cnt_d;
      hold_cnt_q   <= hold_cnt_d;
      trap_armed_q <= trap_armed_d;
    end
  end

  // Event outputs; the interrupt has no mask of any kind
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q      <= 1'b0;
      rst_req_q  <= 1'b0;
      trap_act_q <= 1'b1;
      running_q  <= 1'b1;
    end else begin
      irq_q      <= overflow & ~action_reset;
      rst_req_q  <= (state_d == wdt_pkg::WDT_S_RSTHOLD);
      trap_act_q <= setup_d[wdt_pkg::WDT_BIT_TRAP_ACT];
      // Low-power hold freezes counting, so it also clears this flag
      running_q  <= (state_d == wdt_pkg::WDT_S_RUN) & ~low_power_hold;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= '0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q  <= access_phase ? prdata_d : prdata_q;
      pready_q  <= access_phase;
      pslverr_q <= access_phase & ~addr_hit;
    end
  end

  assign prdata                = prdata_q;
  assign pready                = pready_q;
  assign pslverr               = pslverr_q;
  assign watchdog_overflow_irq = irq_q;
  assign wdt_reset_req         = rst_req_q;
  assign trap_ram_enable       = trap_armed_q;
  assign trap_action_reset     = trap_act_q;
  assign wdt_running           = running_q;

endmodule // wdt_core

// [test/wdt_core_sva.sv]
/* Port checker for wdt_core.
   Assumes an APB master that keeps setup then access order. */
`timescale 1ns/1ps
module wdt_core_sva #(
  parameter int unsigned HF_DIV_W = wdt_pkg::WDT_HF_DIV_W,
  parameter int unsigned LF_DIV_W = wdt_pkg::WDT_LF_DIV_W
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        low_power_hold,
  input wire logic        watchdog_overflow_irq,
  input wire logic        wdt_reset_req,
  input wire logic        trap_ram_enable,
  input wire logic        trap_action_reset,
  input wire logic        wdt_running
);
  logic [4:0] req_len_q;
  wire        wo_reg = paddr == wdt_pkg::WDT_SETUP_ADDR ||
                       paddr == wdt_pkg::WDT_KEY_ADDR;
  wire        mapped = wo_reg || paddr == wdt_pkg::WDT_STATUS_ADDR;

  // Length of the current reset request, in cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) req_len_q <= 5'h00;
    else req_len_q <= wdt_reset_req ? req_len_q + 5'h01 : 5'h00;
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_irq_pulse: assert property (watchdog_overflow_irq |=>
    !watchdog_overflow_irq) else $error("irq longer than one cycle");
  a_irq_not_reset: assert property (watchdog_overflow_irq |->
    !wdt_reset_req) else $error("irq during reset request");
  a_req_max_len: assert property (req_len_q <= 5'h18)
    else $error("reset request too long");
  a_req_exact_len: assert property ($fell(wdt_reset_req) |->
    req_len_q == 5'h18) else $error("reset request not 24 cycles");
  a_reset_restores: assert property ($fell(wdt_reset_req) |->
    ##[0:2] (wdt_running && trap_action_reset && !trap_ram_enable))
    else $error("setup not restored after reset request");
  a_hold_stops: assert property (low_power_hold |=> !wdt_running)
    else $error("running during hold");
  a_hold_quiet: assert property (low_power_hold [*2] |->
    !watchdog_overflow_irq && !$rose(wdt_reset_req))
    else $error("overflow during hold");
  a_apb_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("bus answer not after one wait state");
  a_apb_err: assert property (pready |-> pslverr == !mapped)
    else $error("error response wrong for address");
  a_wo_read: assert property (pready && !pwrite && wo_reg |->
    prdata == 32'h0) else $error("write-only read not zero");

  c_irq: cover property (watchdog_overflow_irq);
  c_req: cover property ($rose(wdt_reset_req));
  c_hold: cover property ($fell(wdt_running) && low_power_hold);
endmodule // wdt_core_sva

bind wdt_core wdt_core_sva #(.HF_DIV_W(HF_DIV_W), .LF_DIV_W(LF_DIV_W))
  wdt_core_sva_i (
    .pclk                  (pclk),
    .presetn               (presetn),
    .psel                  (psel),
    .penable               (penable),
    .pwrite                (pwrite),
    .paddr                 (paddr),
    .prdata                (prdata),
    .pready                (pready),
    .pslverr               (pslverr),
    .low_power_hold        (low_power_hold),
    .watchdog_overflow_irq (watchdog_overflow_irq),
    .wdt_reset_req         (wdt_reset_req),
    .trap_ram_enable       (trap_ram_enable),
    .trap_action_reset     (trap_action_reset),
    .wdt_running           (wdt_running)
  );

// [test/watchdog_timer_with_trap_codes_tb_top.sv]
/* Self-checking bench for wdt_core with short dividers (8 and 7).
   Assumes the checker file is compiled beforehand. */
`timescale 1ns/1ps
module watchdog_timer_with_trap_codes_tb_top;
  localparam logic [11:0] SU = wdt_pkg::WDT_SETUP_ADDR;
  localparam logic [11:0] KY = wdt_pkg::WDT_KEY_ADDR;
  localparam logic [11:0] ST = wdt_pkg::WDT_STATUS_ADDR;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, low_freq_tick = 1'b0, slow_mode = 1'b0;
  logic        low_power_hold = 1'b0, divider_tap_select = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hF;
  logic [31:0] prdata, r;
  logic        pready, pslverr, watchdog_overflow_irq, wdt_reset_req;
  logic        trap_ram_enable, trap_action_reset, wdt_running, err;
  logic [1:0]  lf_q = 2'h0;
  int          miscompares = 0, tests_run = 0, cyc = 0, c;

  wdt_core #(.HF_DIV_W(8), .LF_DIV_W(7)) wdt_core_i (
    .pclk                  (pclk),
    .presetn               (presetn),
    .psel                  (psel),
    .penable               (penable),
    .pwrite                (pwrite),
    .paddr                 (paddr),
    .pwdata                (pwdata),
    .pstrb                 (pstrb),
    .prdata                (prdata),
    .pready                (pready),
    .pslverr               (pslverr),
    .low_freq_tick         (low_freq_tick),
    .slow_mode             (slow_mode),
    .low_power_hold        (low_power_hold),
    .divider_tap_select    (divider_tap_select),
    .watchdog_overflow_irq (watchdog_overflow_irq),
    .wdt_reset_req         (wdt_reset_req),
    .trap_ram_enable       (trap_ram_enable),
    .trap_action_reset     (trap_action_reset),
    .wdt_running           (wdt_running)
  );

  always #5 pclk = ~pclk;
  // Low-frequency tick every third cycle
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    lf_q <= (lf_q == 2'h2) ? 2'h0 : lf_q + 2'h1;
    low_freq_tick <= (lf_q == 2'h2);
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic rst();
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask

  // One APB transfer; an idle cycle follows so strobes never re-rise
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] d);
    int n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk(pready, 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wirq(output int k);
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (watchdog_overflow_irq !== 1'b1 && k < 5000);
  endtask

  task automatic t_reset();
    chk(wdt_running, 1'b1);
    chk(trap_action_reset, 1'b1);
    apb(1'b0, ST, 8'h00);
    chk(r & 32'hF3, 32'h03);
    apb(1'b0, SU, 8'h00);
    chk(r, 32'h0);
    apb(1'b0, 12'h0FC, 8'h00);
    chk(err, 1'b1);
  endtask

  task automatic t_period();
    for (int m = 0; m < 3; m++) begin
      divider_tap_select <= (m == 1);
      slow_mode <= (m == 2);
      for (int k = 0; k < 4; k++) begin
        apb(1'b1, SU, 8'h38 | 8'(k << 1));
        wirq(c);
        wirq(c);
        chk(c, m == 0 ? 4 << (8 - 2 * k) : 12 << (7 - 2 * k));
      end
    end
    divider_tap_select <= 1'b0;
    slow_mode <= 1'b0;
    apb(1'b1, SU, 8'h3F);
    wirq(c);
    wirq(c);
    chk(c, 16);
    apb(1'b0, ST, 8'h00);
    chk(r[1], 1'b0);
  endtask

  // Junk codes and the trap code keep the period; the clear code pushes overflow out
  task automatic t_codes();
    logic [7:0] code [4] = '{8'h00, 8'hFF, 8'hD2, 8'h4E};
    int t0;
    for (int i = 0; i < 4; i++) begin
      wirq(c);
      t0 = cyc;
      apb(1'b1, KY, code[i]);
      wirq(c);
      c = cyc - t0;
      chk(i < 3 ? c == 16 : c > 16 && c <= 24, 1'b1);
    end
    chk(trap_ram_enable, 1'b1);
  endtask

  task automatic t_hold();
    wirq(c);
    apb(1'b1, KY, 8'h4E);
    low_power_hold <= 1'b1;
    repeat (40) @(posedge pclk);
    chk(wdt_running, 1'b0);
    low_power_hold <= 1'b0;
    apb(1'b1, KY, 8'h4E);
    wirq(c);
    chk(c, 16);
  endtask

  task automatic t_disable();
    apb(1'b1, KY, 8'hB1);
    chk(wdt_running, 1'b1);
    apb(1'b1, KY, 8'h4E);
    apb(1'b1, SU, 8'h36);
    chk(wdt_running, 1'b1);
    apb(1'b1, KY, 8'hB1);
    chk(wdt_running, 1'b0);
    repeat (100) @(posedge pclk);
    apb(1'b0, ST, 8'h00);
    chk(r & 32'h0D, 32'h0);
    apb(1'b1, SU, 8'h3E);
    wirq(c);
    wirq(c);
    chk(c, 16);
  endtask

  task automatic t_rst_mode();
    apb(1'b1, SU, 8'h3F);
    c = 0;
    while (wdt_reset_req !== 1'b1 && c < 100) begin
      @(posedge pclk);
      c++;
    end
    c = 0;
    while (wdt_reset_req === 1'b1 && c < 100) begin
      @(posedge pclk);
      c++;
    end
    chk(c, 24);
    repeat (4) @(posedge pclk);
    apb(1'b0, ST, 8'h00);
    chk(r & 32'hF3, 32'h03);
  endtask

  task automatic results();
    $display("miscompares=%0d tests_run=%0d", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    rst();
    t_reset();
    t_period();
    t_codes();
    t_hold();
    t_disable();
    rst();
    t_reset();
    t_rst_mode();
    results();
  end

  initial begin
    #500000;
    miscompares++;
    results();
  end
endmodule // watchdog_timer_with_trap_codes_tb_top
